/* src/vic_pkg.sv */
// Purpose: shared constants and carrier types of the vectored interrupt controller
// Assumes: 32-bit Avalon-MM register window, byte addresses
// Notes:   vector slots are numbered in priority order, slot 0 highest
package vic_pkg;
    localparam int          NSRC      = 12;
    localparam int          NTM       = 10;
    localparam int          PCW       = 13;
    localparam int          STK_DEPTH = 8;
    localparam logic [3:0]  STK_FULL  = 4'h8;
    // vector slots
    localparam int          V_EXT0 = 0;
    localparam int          V_EXT1 = 1;
    localparam int          V_LN3  = 2;
    localparam int          V_CONV = 3;
    localparam int          V_MF0  = 4;
    localparam int          V_NVM  = 9;
    localparam int          V_TB0  = 10;
    localparam int          V_TB1  = 11;
    localparam logic [12:0] VEC_BASE = 13'h0004;
    // register byte offsets
    localparam logic [7:0]  A_CTRL  = 8'h00;
    localparam logic [7:0]  A_FLAG  = 8'h04;
    localparam logic [7:0]  A_EN    = 8'h08;
    localparam logic [7:0]  A_TMF   = 8'h0C;
    localparam logic [7:0]  A_TME   = 8'h10;
    localparam logic [7:0]  A_EDGE  = 8'h14;
    localparam logic [7:0]  A_PSC   = 8'h18;
    localparam logic [7:0]  A_TICK0_CONTROL_REG  = 8'h1C;
    localparam logic [7:0]  A_TICK1_CONTROL_REG  = 8'h20;
    localparam logic [7:0]  A_PULL  = 8'h24;
    localparam logic [7:0]  A_STAT  = 8'h28;
    // field positions and reset values
    localparam int          TB_ON   = 7;
    localparam logic [7:0]  TBC_MSK = 8'h87;
    localparam logic [3:0]  TB1_SH  = 4'h4;
    localparam logic [1:0]  PSC_SYS = 2'h0;
    localparam logic [1:0]  PSC_DV4 = 2'h1;
    localparam logic [1:0]  DIV4_LAST = 2'h3;
    localparam logic [1:0]  EDG_OFF = 2'h0;
    localparam logic [1:0]  EDG_RIS = 2'h1;
    localparam logic [1:0]  EDG_FAL = 2'h2;
    localparam logic [1:0]  EDG_BTH = 2'h3;
    localparam logic [7:0]  RST_PSC = 8'h00;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [31:0] writedata;
    } vic_av_req_t;

    typedef struct packed {
        logic           boundary;  // instruction boundary, may take
        logic           call;      // subroutine call pushes
        logic           ret;       // plain return pops
        logic           return_from_irq_instr;      // return from irq pops, re-enables
        logic [PCW-1:0] pc_next;   // next instruction address
    } vic_core_t;

    typedef struct packed {
        logic                          gie;
        logic [NSRC-1:0]               flag;
        logic [NSRC-1:0]               en;
        logic [NTM-1:0]                tmf;
        logic [NTM-1:0]                tme;
        logic [5:0]                    edg;
        logic [1:0]                    psc;
        logic [7:0]                    tick0_control_reg;
        logic [7:0]                    tick1_control_reg;
        logic [1:0]                    pull;
        logic [1:0]                    pin_q;
        logic                          ln3_q;
        logic [1:0]                    div;
        logic [10:0]                   cnt0;
        logic [10:0]                   cnt1;
        logic [3:0]                    sp;
        logic [STK_DEPTH-1:0][PCW-1:0] stk;
        logic                          pc_load;
        logic [PCW-1:0]                pc_val;
        logic                          wake;
        logic                          ack;
        logic [31:0]                   rdata;
    } vic_state_t;
endpackage : vic_pkg

/* src/vic_top.sv */
// Purpose: vectored interrupt controller with hardware return stack and tick generators
// Assumes: all inputs synchronous to i_core_clk; event inputs are one-cycle pulses
// Notes:   registers on Avalon-MM, one wait state per access
`timescale 1ns/1ns
`default_nettype none
module vic_top
    import vic_pkg::*;
(
    input  wire logic              i_core_clk,        // system clock, 25 MHz
    input  wire logic              i_sys_rst,         // sync reset, high
    input  wire vic_av_req_t       i_av,              // avalon request
    output logic                   o_av_waitrequest,  // avalon wait
    output logic [31:0]            o_av_readdata,     // avalon read data
    input  wire vic_core_t         i_core,            // core sequencing
    output logic                   o_pc_load,         // pulse: load pc
    output logic [PCW-1:0]         o_pc_value,        // pc to load
    output logic                   o_wake,            // pulse: wake core
    input  wire logic [1:0]        i_ext_irq_pins,    // external pins
    input  wire logic              i_msg_rx_irq_out,  // bus ctrl irq level
    input  wire logic              i_conv_done,       // conversion done pulse
    input  wire logic              i_nvm_done,        // nvm cycle end pulse
    input  wire logic [NTM-1:0]    i_tm_match,        // {A,P} per timer
    input  wire logic              i_sub_tick,        // low-speed clock tick
    output logic [1:0]             o_pullup_en        // pin pull-high enables
);
    vic_state_t      s;
    vic_state_t      n;
    logic            acc;
    logic            wr;
    logic            take;
    logic [3:0]      idx;
    logic [NSRC-1:0] pend;
    logic [NSRC-1:0] set;
    logic [NTM-1:0]  tm_set;
    logic            psc_en;
    logic            hit0;
    logic            hit1;

    // vector slots, priority falls with the slot number:
    //   slot 0   external pin 0
    //   slot 1   external pin 1
    //   slot 2   line three, fed by the message receive level
    //   slot 3   conversion done
    //   slot 4   group 0, timer 0 members
    //   slot 5   group 1, timer 1 members
    //   slot 6   group 2, timer 2 members
    //   slot 7   group 3, timer 3 members
    //   slot 8   group 4, timer 4 members
    //   slot 9   memory cycle done
    //   slot 10  tick 0 overflow
    //   slot 11  tick 1 overflow
    // vector address is the base plus four bytes per slot

    // register window, one word each, data in the low bits:
    //   ctrl     bit 0 global enable
    //   flag     one request flag per slot, writable by software
    //   en       one enable per slot
    //   tmf      member flags, never cleared by service
    //   tme      member enables, gate the group flag only
    //   edge     two bits per edge-detected line
    //   psc      prescaler source for both tick dividers
    //   tick0_control_reg     bit 7 on, low three bits period code
    //   tick1_control_reg     same layout, four octaves slower
    //   pull     pull-high enables of the two pins
    //   stat     read only, stack pointer and full bit
    // unmapped reads answer zero, unmapped writes vanish

    // edge detect for one pin under a 2-bit mode
    function automatic logic edge_hit(input logic [1:0] mode, input logic prev, input logic cur);
        case (mode)
            EDG_RIS: edge_hit = !prev && cur;
            EDG_FAL: edge_hit = prev && !cur;
            EDG_BTH: edge_hit = prev != cur;
            default: edge_hit = 1'b0;
        endcase
    endfunction : edge_hit

    // divider overflow when the low sh bits are all ones
    function automatic logic tick_hit(input logic [10:0] cnt, input logic [3:0] sh);
        logic [11:0] mask;
        mask = (12'h001 << sh) - 12'h001;
        tick_hit = (cnt & mask[10:0]) == mask[10:0];
    endfunction : tick_hit

    // lowest set bit wins
    function automatic logic [3:0] first_set(input logic [NSRC-1:0] v);
        first_set = 4'h0;
        for (int k = NSRC - 1; k >= 0; k--) begin
            if (v[k]) begin
                first_set = 4'(k);
            end
        end
    endfunction : first_set

    // one wait state: answer stands at the edge after the request appears
    assign acc              = i_av.read || i_av.write;
    assign wr               = i_av.write && s.ack;
    assign o_av_waitrequest = acc && !s.ack;
    assign o_av_readdata    = s.rdata;
    assign o_pc_load        = s.pc_load;
    assign o_pc_value       = s.pc_val;
    assign o_wake           = s.wake;
    assign o_pullup_en      = s.pull;

    // prescaler source; sub clock arrives as an enable pulse
    always_comb begin
        case (s.psc)
            PSC_SYS: psc_en = 1'b1;
            PSC_DV4: psc_en = s.div == DIV4_LAST;
            default: psc_en = i_sub_tick;
        endcase
    end

    // tick overflows; tick1 sits four octaves below tick0
    assign hit0 = s.tick0_control_reg[TB_ON] && psc_en && tick_hit(s.cnt0, {1'b0, s.tick0_control_reg[2:0]});
    assign hit1 = s.tick1_control_reg[TB_ON] && psc_en && tick_hit(s.cnt1, {1'b0, s.tick1_control_reg[2:0]} + TB1_SH);

    // member events latch; group flag follows an enabled member set
    assign tm_set = i_tm_match;
    always_comb begin
        set          = '0;
        set[V_EXT0]  = edge_hit(s.edg[1:0], s.pin_q[0], i_ext_irq_pins[0]);
        set[V_EXT1]  = edge_hit(s.edg[3:2], s.pin_q[1], i_ext_irq_pins[1]);
        set[V_LN3]   = edge_hit(s.edg[5:4], s.ln3_q, i_msg_rx_irq_out);
        set[V_CONV]  = i_conv_done;
        set[V_NVM]   = i_nvm_done;
        set[V_TB0]   = hit0;
        set[V_TB1]   = hit1;
        for (int g = 0; g < 5; g++) begin
            set[V_MF0 + g] = |(tm_set[2*g +: 2] & s.tme[2*g +: 2]);
        end
    end

    // pending and take; a stack move in the same cycle defers the take
    assign pend = s.flag & s.en;
    assign idx  = first_set(pend);
    assign take = s.gie && |pend && (s.sp != STK_FULL) && i_core.boundary
                  && !(i_core.call || i_core.ret || i_core.return_from_irq_instr);

    // next state
    always_comb begin
        n         = s;
        n.ack     = acc && !s.ack;
        n.pc_load = 1'b0;
        n.pin_q   = i_ext_irq_pins;
        n.ln3_q   = i_msg_rx_irq_out;
        n.div     = s.div + 2'h1;
        // free-running dividers, held at zero while off
        if (!s.tick0_control_reg[TB_ON]) begin
            n.cnt0 = '0;
        end else if (psc_en) begin
            n.cnt0 = s.cnt0 + 11'h001;
        end
        if (!s.tick1_control_reg[TB_ON]) begin
            n.cnt1 = '0;
        end else if (psc_en) begin
            n.cnt1 = s.cnt1 + 11'h001;
        end
        // register read data, captured before the answering edge
        if (acc && !s.ack) begin
            case (i_av.address)
                A_CTRL:  n.rdata = {31'h0, s.gie};
                A_FLAG:  n.rdata = {20'h0, s.flag};
                A_EN:    n.rdata = {20'h0, s.en};
                A_TMF:   n.rdata = {22'h0, s.tmf};
                A_TME:   n.rdata = {22'h0, s.tme};
                A_EDGE:  n.rdata = {26'h0, s.edg};
                A_PSC:   n.rdata = {30'h0, s.psc};
                A_TICK0_CONTROL_REG:  n.rdata = {24'h0, s.tick0_control_reg};
                A_TICK1_CONTROL_REG:  n.rdata = {24'h0, s.tick1_control_reg};
                A_PULL:  n.rdata = {30'h0, s.pull};
                A_STAT:  n.rdata = {27'h0, s.sp == STK_FULL, s.sp};
                default: n.rdata = 32'h0;
            endcase
        end
        // software writes; reserved bits dropped
        if (wr) begin
            case (i_av.address)
                A_CTRL:  n.gie  = i_av.writedata[0];
                A_FLAG:  n.flag = i_av.writedata[NSRC-1:0];
                A_EN:    n.en   = i_av.writedata[NSRC-1:0];
                A_TMF:   n.tmf  = i_av.writedata[NTM-1:0];
                A_TME:   n.tme  = i_av.writedata[NTM-1:0];
                A_EDGE:  n.edg  = i_av.writedata[5:0];
                A_PSC:   n.psc  = i_av.writedata[1:0];
                A_TICK0_CONTROL_REG:  n.tick0_control_reg = i_av.writedata[7:0] & TBC_MSK;
                A_TICK1_CONTROL_REG:  n.tick1_control_reg = i_av.writedata[7:0] & TBC_MSK;
                A_PULL:  n.pull = i_av.writedata[1:0];
                default: n.gie  = n.gie;
            endcase
        end
        // stack moves from the core
        if (i_core.call && s.sp != STK_FULL) begin
            n.stk[s.sp[2:0]] = i_core.pc_next;
            n.sp             = s.sp + 4'h1;
        end else if ((i_core.ret || i_core.return_from_irq_instr) && s.sp != 4'h0) begin
            n.sp      = s.sp - 4'h1;
            n.pc_load = 1'b1;
            n.pc_val  = s.stk[s.sp[2:0] - 3'h1];
            n.gie     = i_core.return_from_irq_instr ? 1'b1 : n.gie;
        end
        // take: push, vector, block nesting, clear the serviced flag only
        if (take) begin
            n.stk[s.sp[2:0]] = i_core.pc_next;
            n.sp             = s.sp + 4'h1;
            n.pc_load        = 1'b1;
            n.pc_val         = VEC_BASE + {7'h0, idx, 2'h0};
            n.gie            = 1'b0;
            n.flag[idx]      = 1'b0;
        end
        // hardware sets win over software and service clears
        n.flag = n.flag | set;
        n.tmf  = n.tmf | tm_set;
        // wake on any rising flag, enables ignored
        n.wake = |(n.flag & ~s.flag) || |(n.tmf & ~s.tmf);
    end

    // state register
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            s      <= '0;
            s.psc  <= RST_PSC[1:0];
        end else begin
            s <= n;
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    a_gie_blocks_take: assert property (!s.gie |-> !take)
        else $error("vector taken with global enable low");
    a_take_loads_vector: assert property (take |=> o_pc_load && o_pc_value == VEC_BASE + {7'h0, $past(idx), 2'h0})
        else $error("vector address wrong after take");
    a_take_clears_gie: assert property (take |=> !s.gie && s.sp == $past(s.sp) + 4'h1)
        else $error("take did not push or clear global enable");
    a_full_blocks_take: assert property (s.sp == STK_FULL |-> !take)
        else $error("take with full stack");
    a_return_from_irq_instr_resumes: assert property (i_core.return_from_irq_instr && !i_core.call && s.sp != 4'h0
        |=> o_pc_load && s.gie && o_pc_value == $past(s.stk[s.sp[2:0] - 3'h1]))
        else $error("return did not restore pc");
    a_flag_holds_set: assert property (s.flag[V_CONV] && !take && !wr |=> s.flag[V_CONV])
        else $error("flag dropped without service or write");
    a_wake_on_rise: assert property (!s.flag[V_CONV] && i_conv_done |=> o_wake)
        else $error("no wake on flag rise");
    a_ext_rise_sets: assert property (s.edg[1:0] == EDG_RIS && !s.pin_q[0] && i_ext_irq_pins[0]
        |=> s.flag[V_EXT0])
        else $error("rising edge did not set pin flag");
    a_group_keeps_member: assert property (take && idx >= 4'h4 && idx <= 4'h8 && !wr
        |=> s.tmf == ($past(s.tmf) | $past(i_tm_match)))
        else $error("member flags changed on group service");
    // a source change by software does not restart the free-running divider; write cycles are still left out
    a_psc_div4_rate: assert property (s.psc == PSC_DV4 && psc_en && !wr
        |=> (s.psc != PSC_DV4 || !psc_en) [*3])
        else $error("divide-by-four prescaler too fast");

    // service clears the slot flag unless a new event lands in the same cycle
    a_take_clears_flag: assert property (take && !set[idx] |=> !s.flag[$past(idx)])
        else $error("serviced flag still set");

    // every event is latched, service or not
    a_set_latches: assert property (|set |=> (s.flag & $past(set)) == $past(set))
        else $error("event not latched into flag");

    // the core is only redirected by a take or a pop
    a_load_has_cause: assert property (!take && !i_core.ret && !i_core.return_from_irq_instr |=> !o_pc_load)
        else $error("pc load without take or return");

    // a wake pulse always follows a flag rise
    a_wake_has_rise: assert property (o_wake |-> ((s.flag & ~$past(s.flag)) != '0)
        || ((s.tmf & ~$past(s.tmf)) != '0))
        else $error("wake without a rising flag");

    // stack pointer never runs past the depth
    a_sp_bounded: assert property (s.sp <= STK_FULL)
        else $error("stack pointer beyond depth");

    // a call on a full stack is dropped, not wrapped
    a_call_full_kept: assert property (i_core.call && s.sp == STK_FULL |=> s.sp == STK_FULL)
        else $error("call on full stack moved pointer");

    // plain return restores the pc but leaves the global enable alone
    a_ret_keeps_gie: assert property (i_core.ret && !i_core.return_from_irq_instr && !i_core.call && s.sp != 4'h0 && !wr
        |=> o_pc_load && s.gie == $past(s.gie))
        else $error("plain return changed global enable");

    // dividers that are off never raise a tick
    a_tick0_off_quiet: assert property (!s.tick0_control_reg[TB_ON] |-> !hit0)
        else $error("tick 0 fired while off");
    a_tick1_off_quiet: assert property (!s.tick1_control_reg[TB_ON] |-> !hit1)
        else $error("tick 1 fired while off");

    // edge select off silences the pin
    a_edge_off_quiet: assert property (s.edg[1:0] == EDG_OFF |-> !set[V_EXT0])
        else $error("pin event with edge select off");

    // line three follows the message level edge
    a_ln3_rise_sets: assert property (s.edg[5:4] == EDG_RIS && !s.ln3_q && i_msg_rx_irq_out
        |=> s.flag[V_LN3])
        else $error("line three rise did not set flag");

    // falling mode on pin 1
    a_ext1_fall_sets: assert property (s.edg[3:2] == EDG_FAL && s.pin_q[1] && !i_ext_irq_pins[1]
        |=> s.flag[V_EXT1])
        else $error("falling edge did not set pin 1 flag");

    // system clock source ticks every cycle
    a_psc_sys_rate: assert property (s.psc == PSC_SYS |-> psc_en)
        else $error("system clock prescaler stalled");

    // memory done always lands in its flag
    a_nvm_sets: assert property (i_nvm_done |=> s.flag[V_NVM])
        else $error("memory done flag not set");

    // no pending slot above the one taken
    a_prio_first: assert property (take |-> (pend & ((NSRC'(1) << idx) - NSRC'(1))) == '0)
        else $error("lower priority slot taken first");

    // register bus answers after exactly one wait state
    a_one_wait: assert property (acc && !s.ack |=> !o_av_waitrequest)
        else $error("register access not answered in one wait state");

    c_take: cover property (take);
    c_nested_take: cover property (take ##[1:20] take);
    c_return_from_irq_instr: cover property (take ##[1:50] i_core.return_from_irq_instr);
    c_full_block: cover property (s.sp == STK_FULL && s.gie && |pend);
    c_group_take: cover property (take && idx == 4'h6);
endmodule : vic_top
`default_nettype wire

/* testbench/vic_core_model.sv */
// Purpose: core model, drives instruction boundary and call or return pulses
// Assumes: i_cmd is a one-cycle pulse from the bench
// Notes:   no boundary in the fetch cycle right after a pc load
`timescale 1ns/1ns
`default_nettype none
module vic_core_model
    import vic_pkg::*;
(
    input  wire logic           i_core_clk, // system clock
    input  wire logic           i_sys_rst,  // sync reset, high
    input  wire logic [1:0]     i_cmd,      // 1 call, 2 ret, 3 return_from_irq_instr
    input  wire logic [PCW-1:0] i_pc_next,  // address to push
    input  wire logic           i_pc_load,  // load from controller
    output var  vic_core_t      o_core      // core sequencing
);
    logic fetch_r; // fetch after any pc load, cannot be interrupted
    // fetch cycle follows every load
    always_ff @(posedge i_core_clk) begin
        fetch_r <= i_pc_load && !i_sys_rst;
    end
    // each service routine is closed by return-from-irq
    always_comb begin
        o_core.boundary = !fetch_r && !i_sys_rst;
        o_core.call     = (i_cmd == 2'h1);
        o_core.ret      = (i_cmd == 2'h2);
        o_core.return_from_irq_instr     = (i_cmd == 2'h3);
        o_core.pc_next  = i_pc_next;
    end
endmodule : vic_core_model
`default_nettype wire

/* testbench/vectored_interrupt_controller_test.sv */
// Purpose: self-checking bench of the interrupt controller
// Assumes: one wait state per register access, core model as far side
// Notes:   expected loads and reads are queued, a monitor compares them
`timescale 1ns/1ns
`default_nettype none
module vectored_interrupt_controller_test
    import vic_pkg::*;
;
    logic           clk = 1'b0;
    logic           rst;
    vic_av_req_t    av;
    logic           o_av_waitrequest, o_pc_load, o_wake;
    logic [31:0]    o_av_readdata;
    logic [PCW-1:0] o_pc_value, pcx;
    vic_core_t      core_s;
    logic [1:0]     cmd, pins, pull;
    logic           msg, conv, nvm, subt;
    logic [NTM-1:0] tm;
    logic [PCW-1:0] exp_pc[$];
    logic [31:0]    exp_rd[$];
    int             n_mismatch = 0, samples_checked = 0, n_wake = 0, w0, p;

    always #20 clk = ~clk;

    vic_top dut (.i_core_clk(clk), .i_sys_rst(rst), .i_av(av), .o_av_waitrequest(o_av_waitrequest),
        .o_av_readdata(o_av_readdata), .i_core(core_s), .o_pc_load(o_pc_load), .o_pc_value(o_pc_value),
        .o_wake(o_wake), .i_ext_irq_pins(pins), .i_msg_rx_irq_out(msg), .i_conv_done(conv),
        .i_nvm_done(nvm), .i_tm_match(tm), .i_sub_tick(subt), .o_pullup_en(pull));
    vic_core_model core_m (.i_core_clk(clk), .i_sys_rst(rst), .i_cmd(cmd), .i_pc_next(pcx),
        .i_pc_load(o_pc_load), .o_core(core_s));

    task automatic fail(input string m);
        n_mismatch++;
        $display("unexpected at %0t: %s", $time, m);
    endtask : fail
    task automatic cmp_pc(input logic [PCW-1:0] e, input logic [PCW-1:0] g);
        samples_checked++;
        if (g !== e) fail("pc load value");
    endtask : cmp_pc
    task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) fail("word value");
    endtask : cmp_word
    task automatic give_verdict;
        $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict
    // one avalon access, held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        av <= '{read: !w, write: w, address: a, writedata: d};
        do begin
            @(posedge clk);
            n++;
        end while (o_av_waitrequest !== 1'b0 && n < 20);
        if (o_av_waitrequest !== 1'b0) fail("bus hang");
        av <= '0;
        @(posedge clk);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_rd.push_back(e);
        bus(1'b0, a, '0);
    endtask : rd
    task automatic core(input logic [1:0] c);
        cmd <= c;
        @(posedge clk);
        cmd <= 2'h0;
        @(posedge clk);
    endtask : core
    task automatic rst_dut;
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask : rst_dut
    function automatic logic [PCW-1:0] vec(input int s);
        return VEC_BASE + PCW'(4 * s);
    endfunction : vec

    // monitor: settled outputs at the falling edge, oldest note first
    always @(negedge clk) begin
        if (o_wake === 1'b1) n_wake++;
        if (o_pc_load === 1'b1) begin
            if (exp_pc.size() == 0) fail("pc load with none expected");
            else cmp_pc(exp_pc.pop_front(), o_pc_value);
        end
        if (av.read && o_av_waitrequest === 1'b0) cmp_word(exp_rd.pop_front(), o_av_readdata);
    end

    // watchdog, far beyond the longest tick wait
    initial begin
        repeat (30000) @(posedge clk);
        fail("timeout");
        give_verdict();
    end

    initial begin
        rst = 1'b1; av = '0; cmd = 2'h0; pins = 2'h0; msg = 1'b0;
        conv = 1'b0; nvm = 1'b0; tm = '0; subt = 1'b0;
        void'($urandom(73563));
        pcx = PCW'($urandom);
        rst_dut();
        rd(A_PSC, RST_PSC);
        rd(8'h3C, 32'h0);
        wr(A_PULL, 32'h3); @(posedge clk);
        cmp_word(32'h3, {30'h0, pull});
        w0 = int'($urandom);
        wr(A_PSC, 32'(w0)); rd(A_PSC, 32'(w0) & 32'h3);
        // every edge mode on pin 0, rise then fall
        for (int c = 0; c < 4; c++) begin
            wr(A_EDGE, 32'(c)); wr(A_FLAG, 32'h0);
            pins[0] <= 1'b1; repeat (3) @(posedge clk);
            rd(A_FLAG, 32'(c[0]));
            wr(A_FLAG, 32'h0);
            pins[0] <= 1'b0; repeat (3) @(posedge clk);
            rd(A_FLAG, 32'(c[1]));
        end
        // flag and wake without enable, then held while blocked
        wr(A_FLAG, 32'h0); wr(A_CTRL, 32'h1); wr(A_EN, 32'h0); w0 = n_wake;
        conv <= 1'b1; @(posedge clk); conv <= 1'b0; repeat (3) @(posedge clk);
        rd(A_FLAG, 32'h8);
        cmp_word(32'(w0 + 1), 32'(n_wake));
        wr(A_CTRL, 32'h0); wr(A_EN, 32'h8); repeat (5) @(posedge clk);
        rd(A_FLAG, 32'h8);
        exp_pc.push_back(vec(V_CONV));
        wr(A_CTRL, 32'h1); repeat (3) @(posedge clk);
        rd(A_FLAG, 32'h0);
        rd(A_CTRL, 32'h0);
        exp_pc.push_back(pcx); core(2'h3);
        rd(A_CTRL, 32'h1);
        // simultaneous pins, line three and memory: served in slot order
        wr(A_CTRL, 32'h0); wr(A_EDGE, 32'h15); wr(A_EN, 32'h207);
        pins <= 2'h3; msg <= 1'b1; nvm <= 1'b1; @(posedge clk); nvm <= 1'b0;
        exp_pc.push_back(vec(V_EXT0)); exp_pc.push_back(pcx);
        exp_pc.push_back(vec(V_EXT1)); exp_pc.push_back(pcx);
        exp_pc.push_back(vec(V_LN3)); exp_pc.push_back(pcx);
        exp_pc.push_back(vec(V_NVM)); exp_pc.push_back(pcx);
        wr(A_CTRL, 32'h1);
        repeat (4) begin
            repeat (4) @(posedge clk);
            core(2'h3);
        end
        rd(A_FLAG, 32'h0);
        // group take keeps the member flag
        wr(A_TME, 32'h20); wr(A_EN, 32'h40);
        exp_pc.push_back(vec(V_MF0 + 2));
        tm <= 10'h020; @(posedge clk); tm <= '0; repeat (4) @(posedge clk);
        rd(A_TMF, 32'h20);
        exp_pc.push_back(pcx); core(2'h3);
        // both tick generators at one random period code
        p = $urandom_range(7, 0);
        wr(A_CTRL, 32'h0); wr(A_PSC, 32'h0); wr(A_FLAG, 32'h0);
        wr(A_TICK0_CONTROL_REG, 32'h80 | 32'(p)); wr(A_TICK1_CONTROL_REG, 32'h80 | 32'(p));
        repeat ((1 << p) + 4) @(posedge clk);
        rd(A_FLAG, 32'h400);
        repeat (16 << p) @(posedge clk);
        rd(A_FLAG, 32'hC00);
        // full stack refuses until a pop
        rst_dut(); wr(A_EN, 32'h8);
        repeat (8) core(2'h1);
        rd(A_STAT, 32'h18);
        wr(A_CTRL, 32'h1);
        conv <= 1'b1; @(posedge clk); conv <= 1'b0; repeat (5) @(posedge clk);
        rd(A_FLAG, 32'h8);
        exp_pc.push_back(pcx); exp_pc.push_back(vec(V_CONV));
        core(2'h2); repeat (4) @(posedge clk);
        rd(A_STAT, 32'h18);
        cmp_word(32'h0, 32'(exp_pc.size() + exp_rd.size()));
        give_verdict();
    end
endmodule : vectored_interrupt_controller_test
`default_nettype wire
